// ==== include/mtf_cfg.svh ====
// Constants of the instruction timing and flag block
`ifndef MTF_CFG_SVH
`define MTF_CFG_SVH
`define MTF_CLK_PER_CYCLE 3'h4
`define MTF_CYC_ONE 2'h1
`define MTF_CYC_TWO 2'h2
`define MTF_BCD_LIMIT 4'h9
`define MTF_BCD_ADJ 4'h6
`define MTF_ADDR_ACC 4'h0
`define MTF_ADDR_MEM 4'h1
`define MTF_ADDR_OPC 4'h2
`define MTF_ADDR_STAT 4'h3
`define MTF_ADDR_TABLE_HIGH_BYTE 4'h4
`define MTF_ADDR_CYC 4'h5
`define MTF_ADDR_WDT 4'h6
`define MTF_ADDR_OPT 4'h7
`define MTF_ADDR_ROM 4'h8
`define MTF_ST_Z 0
`define MTF_ST_C 1
`define MTF_ST_HC 2
`define MTF_ST_VF 3
`define MTF_ST_PWDN 4
`define MTF_ST_TMO 5
`endif

// ==== include/mtf_pkg.sv ====
// Types of the instruction timing and flag block
package mtf_pkg;
   typedef enum logic [5:0] {
      OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DECADJ, OP_AND, OP_OR, OP_XOR,
      OP_CPL, OP_INC, OP_DEC, OP_RR, OP_RL, OP_RRC, OP_RLC, OP_MOV_AM,
      OP_MOV_MA, OP_MOV_AX, OP_BCLR, OP_BSET, OP_CLR, OP_SET, OP_SWAP,
      OP_JMP, OP_CALL, OP_RET, OP_RETAX, OP_INTRET, OP_SZ, OP_SZB, OP_SNZB,
      OP_INCSKIP, OP_DECSKIP, OP_TRDC, OP_TRDL, OP_CLRWDT, OP_WDT1, OP_WDT2, OP_HALT
   } mtf_op_t;
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_EXTRA} mtf_state_t;
endpackage

// ==== rtl/mtf_alu.sv ====
// Arithmetic and logic unit with flag results
`include "mtf_cfg.svh"
module mtf_alu (
   // Operation
   input wire mtf_pkg::mtf_op_t op,
   input wire logic [7:0] acc,
   input wire logic [7:0] opnd,
   input wire logic [2:0] bit_sel,
   input wire logic c_in,
   input wire logic hc_in,
   // Result
   output logic [7:0] res,
   output logic z_out,
   output logic c_out,
   output logic hc_out,
   output logic vf_out
);
   logic [8:0] sum;
   logic [4:0] low;
   logic [4:0] hi;
   logic ac1;
   always_comb
   begin
      sum = 9'h000;
      low = 5'h00;
      hi = 5'h00;
      ac1 = 1'b0;
      res = opnd;
      c_out = c_in;
      hc_out = hc_in;
      vf_out = 1'b0;
      case (op)
         mtf_pkg::OP_ADD, mtf_pkg::OP_ADC:
         begin
            sum = {1'b0, acc} + {1'b0, opnd} + {8'h00, op == mtf_pkg::OP_ADC && c_in};
            low = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, op == mtf_pkg::OP_ADC && c_in};
            res = sum[7:0];
            c_out = sum[8];
            hc_out = low[4];
            vf_out = (acc[7] == opnd[7]) && (res[7] != acc[7]);
         end
         mtf_pkg::OP_SUB, mtf_pkg::OP_SBC:
         begin
            sum = {1'b0, acc} + {1'b0, ~opnd} + {8'h00, op == mtf_pkg::OP_SUB || c_in};
            low = {1'b0, acc[3:0]} + {1'b0, ~opnd[3:0]} + {4'h0, op == mtf_pkg::OP_SUB || c_in};
            res = sum[7:0];
            c_out = sum[8];
            hc_out = low[4];
            vf_out = (acc[7] != opnd[7]) && (res[7] != acc[7]);
         end
         mtf_pkg::OP_DECADJ:
         begin
            if (acc[3:0] > `MTF_BCD_LIMIT || hc_in)
            begin
               low = {1'b0, acc[3:0]} + {1'b0, `MTF_BCD_ADJ};
               ac1 = ~hc_in;
            end
            else
               low = {1'b0, acc[3:0]};
            hi = {1'b0, acc[7:4]} + {4'h0, ac1};
            if (hi > {1'b0, `MTF_BCD_LIMIT} || c_in)
            begin
               hi = hi + {1'b0, `MTF_BCD_ADJ};
               c_out = 1'b1;
            end
            res = {hi[3:0], low[3:0]};
         end
         mtf_pkg::OP_AND: res = acc & opnd;
         mtf_pkg::OP_OR: res = acc | opnd;
         mtf_pkg::OP_XOR: res = acc ^ opnd;
         mtf_pkg::OP_CPL: res = ~opnd;
         mtf_pkg::OP_INC, mtf_pkg::OP_INCSKIP: res = opnd + 8'h01;
         mtf_pkg::OP_DEC, mtf_pkg::OP_DECSKIP: res = opnd - 8'h01;
         mtf_pkg::OP_RR: res = {opnd[0], opnd[7:1]};
         mtf_pkg::OP_RL: res = {opnd[6:0], opnd[7]};
         mtf_pkg::OP_RRC:
         begin
            res = {c_in, opnd[7:1]};
            c_out = opnd[0];
         end
         mtf_pkg::OP_RLC:
         begin
            res = {opnd[6:0], c_in};
            c_out = opnd[7];
         end
         mtf_pkg::OP_MOV_MA: res = acc;
         mtf_pkg::OP_BCLR: res = opnd & ~(8'h01 << bit_sel);
         mtf_pkg::OP_BSET: res = opnd | (8'h01 << bit_sel);
         mtf_pkg::OP_CLR: res = 8'h00;
         mtf_pkg::OP_SET: res = 8'hFF;
         mtf_pkg::OP_SWAP: res = {opnd[3:0], opnd[7:4]};
         default: res = opnd;
      endcase
      z_out = (res == 8'h00);
   end
endmodule // mtf_alu

// ==== rtl/mtf_wdt_clr.sv ====
// Watchdog clear sequencing for one-time and two-instruction options
module mtf_wdt_clr (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Control
   input wire logic two_inst,
   input wire logic fire,
   input wire mtf_pkg::mtf_op_t op,
   // Result
   output logic wdt_clr
);
   typedef struct packed {
      logic seen1;
      logic seen2;
   } mtf_wdt_state_t;
   mtf_wdt_state_t st_ff;
   mtf_wdt_state_t nxt_st;
   always_comb
   begin
      nxt_st = st_ff;
      wdt_clr = 1'b0;
      if (fire)
      begin
         if (op == mtf_pkg::OP_CLRWDT && !two_inst)
            wdt_clr = 1'b1;
         else if (two_inst && op == mtf_pkg::OP_WDT1)
         begin
            if (st_ff.seen2)
               wdt_clr = 1'b1;
            else
               nxt_st.seen1 = 1'b1;
         end
         else if (two_inst && op == mtf_pkg::OP_WDT2)
         begin
            if (st_ff.seen1)
               wdt_clr = 1'b1;
            else
               nxt_st.seen2 = 1'b1;
         end
         if (wdt_clr)
            nxt_st = '0;
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end
endmodule // mtf_wdt_clr

// ==== rtl/mtf_core.sv ====
// Instruction timing and flag control with Avalon-MM register access
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`include "mtf_cfg.svh"
// Operation
// - Add and subtract forms update zero, carry, aux carry and overflow.
// - Decimal adjust writes to memory and may change only carry.
// - Logic and complement update only zero, one cycle unless PC low written.
// - Increment and decrement update only the zero flag.
// - Plain rotates keep flags; carry rotates cycle bits through carry only.
// - Moves, bit and byte set/clear and no-op: no flags, one cycle.
// - Jump, call and the returns take two cycles, no flags.
// - Skip tests take one cycle plus one when the skip is taken.
// - A single-cycle write to PC low adds one extra cycle.
// - Memory increment/decrement skips get both extra cycles where each applies.
// - Table read: page word low to memory, high to table high, two cycles.
// - Single watchdog clear clears counter, time-out and power-down flags.
// - Pre-clears clear time-out and power-down only when watchdog clears.
// - Two-instruction option needs both pre-clears; one-time uses single clear.
// - Power-down entry takes one cycle and updates time-out, power-down.
// - Decimal adjust adds six per nibble over nine or carried.
// - Add with carry sums accumulator, memory byte and carry together.
module mtf_core (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Status
   output logic busy,
   output logic wdt_clear_pulse
);
   typedef struct packed {
      mtf_pkg::mtf_state_t state;
      logic [7:0] accumulator_reg;
      logic [7:0] mem_byte;
      logic [7:0] table_high_byte;
      logic [5:0] status;
      logic [5:0] opcode;
      logic [2:0] bit_sel;
      logic to_pcl;
      logic two_inst;
      logic [14:0] rom_word;
      logic [1:0] cycles;
      logic [1:0] cyc_left;
      logic [2:0] clk_cnt;
      logic skip_pending;
      logic [7:0] wdt_count;
      logic [31:0] rdata;
      logic ack;
      logic busy;
      logic wdt_pulse;
   } mtf_core_state_t;
   mtf_core_state_t st_ff;
   mtf_core_state_t nxt_st;
   mtf_pkg::mtf_op_t op;
   logic [7:0] alu_res;
   logic alu_z;
   logic alu_c;
   logic alu_hc;
   logic alu_vf;
   logic fire;
   logic wdt_clr;
   logic bus_req;
   assign op = mtf_pkg::mtf_op_t'(st_ff.opcode);
   assign bus_req = (avs_read || avs_write) && !st_ff.ack;
   // Decode only once, on the first clock of the first instruction cycle
   assign fire = (st_ff.state == mtf_pkg::ST_EXEC) && st_ff.clk_cnt == 3'h0
      && st_ff.cyc_left == 2'h0;
   mtf_alu u_alu (
      .op(op),
      .acc(st_ff.accumulator_reg),
      .opnd(st_ff.mem_byte),
      .bit_sel(st_ff.bit_sel),
      .c_in(st_ff.status[`MTF_ST_C]),
      .hc_in(st_ff.status[`MTF_ST_HC]),
      .res(alu_res),
      .z_out(alu_z),
      .c_out(alu_c),
      .hc_out(alu_hc),
      .vf_out(alu_vf)
   );
   mtf_wdt_clr u_wdt (
      .clk_sys(clk_sys),
      .srst(srst),
      .two_inst(st_ff.two_inst),
      .fire(fire),
      .op(op),
      .wdt_clr(wdt_clr)
   );
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.ack = 1'b0;
      nxt_st.wdt_pulse = 1'b0;
      nxt_st.wdt_count = st_ff.wdt_count + 8'h01;
      // Register access, opcode writes only accepted while idle
      if (bus_req && !(avs_address == `MTF_ADDR_OPC && avs_write
         && st_ff.state != mtf_pkg::ST_IDLE))
      begin
         nxt_st.ack = 1'b1;
         nxt_st.rdata = 32'h0000_0000;
         if (avs_write)
         begin
            case (avs_address)
               `MTF_ADDR_ACC: nxt_st.accumulator_reg = avs_writedata[7:0];
               `MTF_ADDR_MEM: nxt_st.mem_byte = avs_writedata[7:0];
               `MTF_ADDR_STAT: nxt_st.status = avs_writedata[5:0];
               `MTF_ADDR_OPT: nxt_st.two_inst = avs_writedata[0];
               `MTF_ADDR_ROM: nxt_st.rom_word = avs_writedata[14:0];
               `MTF_ADDR_OPC:
               begin
                  nxt_st.opcode = avs_writedata[5:0];
                  nxt_st.bit_sel = avs_writedata[10:8];
                  nxt_st.to_pcl = avs_writedata[16];
                  nxt_st.state = mtf_pkg::ST_EXEC;
                  nxt_st.clk_cnt = 3'h0;
                  nxt_st.busy = 1'b1;
               end
               default: nxt_st.ack = 1'b1;
            endcase
         end
         else
         begin
            case (avs_address)
               `MTF_ADDR_ACC: nxt_st.rdata = {24'h000000, st_ff.accumulator_reg};
               `MTF_ADDR_MEM: nxt_st.rdata = {24'h000000, st_ff.mem_byte};
               `MTF_ADDR_OPC: nxt_st.rdata = {26'h0000000, st_ff.opcode};
               `MTF_ADDR_STAT: nxt_st.rdata = {26'h0000000, st_ff.status};
               `MTF_ADDR_TABLE_HIGH_BYTE: nxt_st.rdata = {24'h000000, st_ff.table_high_byte};
               `MTF_ADDR_CYC:
                  nxt_st.rdata = {29'h00000000, st_ff.skip_pending, st_ff.cycles};
               `MTF_ADDR_WDT: nxt_st.rdata = {24'h000000, st_ff.wdt_count};
               `MTF_ADDR_OPT: nxt_st.rdata = {31'h00000000, st_ff.two_inst};
               `MTF_ADDR_ROM: nxt_st.rdata = {17'h00000, st_ff.rom_word};
               default: nxt_st.rdata = 32'h0000_0000;
            endcase
         end
      end
      if (wdt_clr)
      begin
         nxt_st.wdt_count = 8'h00;
         nxt_st.wdt_pulse = 1'b1;
         nxt_st.status[`MTF_ST_TMO] = 1'b0;
         nxt_st.status[`MTF_ST_PWDN] = 1'b0;
      end
      case (st_ff.state)
         mtf_pkg::ST_IDLE: nxt_st.busy = nxt_st.busy;
         mtf_pkg::ST_EXEC:
         begin
            nxt_st.clk_cnt = st_ff.clk_cnt + 3'h1;
            if (fire)
            begin
               nxt_st.cycles = `MTF_CYC_ONE;
               nxt_st.skip_pending = 1'b0;
               if (st_ff.skip_pending)
                  nxt_st.cycles = `MTF_CYC_ONE;
               else
               begin
                  case (op)
                     mtf_pkg::OP_ADD, mtf_pkg::OP_ADC, mtf_pkg::OP_SUB, mtf_pkg::OP_SBC:
                     begin
                        nxt_st.status[`MTF_ST_Z] = alu_z;
                        nxt_st.status[`MTF_ST_C] = alu_c;
                        nxt_st.status[`MTF_ST_HC] = alu_hc;
                        nxt_st.status[`MTF_ST_VF] = alu_vf;
                        if (st_ff.to_pcl)
                           nxt_st.mem_byte = alu_res;
                        else
                           nxt_st.accumulator_reg = alu_res;
                     end
                     mtf_pkg::OP_DECADJ:
                     begin
                        nxt_st.mem_byte = alu_res;
                        nxt_st.status[`MTF_ST_C] = alu_c;
                     end
                     mtf_pkg::OP_AND, mtf_pkg::OP_OR, mtf_pkg::OP_XOR, mtf_pkg::OP_CPL,
                     mtf_pkg::OP_INC, mtf_pkg::OP_DEC:
                     begin
                        nxt_st.status[`MTF_ST_Z] = alu_z;
                        if (st_ff.bit_sel[0])
                           nxt_st.mem_byte = alu_res;
                        else
                           nxt_st.accumulator_reg = alu_res;
                     end
                     mtf_pkg::OP_RR, mtf_pkg::OP_RL, mtf_pkg::OP_RRC, mtf_pkg::OP_RLC:
                     begin
                        nxt_st.status[`MTF_ST_C] = alu_c;
                        if (st_ff.bit_sel[0])
                           nxt_st.mem_byte = alu_res;
                        else
                           nxt_st.accumulator_reg = alu_res;
                     end
                     mtf_pkg::OP_MOV_AM, mtf_pkg::OP_SWAP:
                        nxt_st.accumulator_reg = (op == mtf_pkg::OP_SWAP) ? alu_res
                           : st_ff.mem_byte;
                     mtf_pkg::OP_MOV_AX: nxt_st.accumulator_reg = st_ff.mem_byte;
                     mtf_pkg::OP_MOV_MA, mtf_pkg::OP_BCLR, mtf_pkg::OP_BSET,
                     mtf_pkg::OP_CLR, mtf_pkg::OP_SET:
                        nxt_st.mem_byte = alu_res;
                     mtf_pkg::OP_JMP, mtf_pkg::OP_CALL, mtf_pkg::OP_RET, mtf_pkg::OP_INTRET:
                        nxt_st.cycles = `MTF_CYC_TWO;
                     mtf_pkg::OP_RETAX:
                     begin
                        nxt_st.cycles = `MTF_CYC_TWO;
                        nxt_st.accumulator_reg = st_ff.mem_byte;
                     end
                     mtf_pkg::OP_SZ: nxt_st.skip_pending = (st_ff.mem_byte == 8'h00);
                     mtf_pkg::OP_SZB: nxt_st.skip_pending = !st_ff.mem_byte[st_ff.bit_sel];
                     mtf_pkg::OP_SNZB: nxt_st.skip_pending = st_ff.mem_byte[st_ff.bit_sel];
                     mtf_pkg::OP_INCSKIP, mtf_pkg::OP_DECSKIP:
                     begin
                        nxt_st.skip_pending = alu_z;
                        if (st_ff.to_pcl)
                           nxt_st.mem_byte = alu_res;
                        else
                           nxt_st.accumulator_reg = alu_res;
                     end
                     mtf_pkg::OP_TRDC, mtf_pkg::OP_TRDL:
                     begin
                        nxt_st.cycles = `MTF_CYC_TWO;
                        nxt_st.mem_byte = st_ff.rom_word[7:0];
                        nxt_st.table_high_byte = {1'b0, st_ff.rom_word[14:8]};
                     end
                     mtf_pkg::OP_HALT:
                     begin
                        nxt_st.status[`MTF_ST_PWDN] = 1'b1;
                        nxt_st.status[`MTF_ST_TMO] = 1'b0;
                     end
                     default: nxt_st.cycles = `MTF_CYC_ONE;
                  endcase
                  // PC low write stalls one more cycle on all forms but jumps, calls, returns, halt, watchdog clears and no-op
                  if (st_ff.to_pcl && op != mtf_pkg::OP_JMP && op != mtf_pkg::OP_CALL
                     && op != mtf_pkg::OP_RET && op != mtf_pkg::OP_RETAX
                     && op != mtf_pkg::OP_INTRET && op != mtf_pkg::OP_HALT
                     && op != mtf_pkg::OP_CLRWDT && op != mtf_pkg::OP_WDT1
                     && op != mtf_pkg::OP_WDT2 && op != mtf_pkg::OP_NOP)
                     nxt_st.cycles = nxt_st.cycles + `MTF_CYC_ONE;
               end
               nxt_st.cyc_left = nxt_st.cycles;
            end
            else if (st_ff.clk_cnt == `MTF_CLK_PER_CYCLE - 3'h1)
            begin
               nxt_st.clk_cnt = 3'h0;
               nxt_st.cyc_left = st_ff.cyc_left - 2'h1;
               if (st_ff.cyc_left == 2'h1)
               begin
                  if (st_ff.skip_pending)
                  begin
                     // Skip costs one cycle of four clocks
                     nxt_st.state = mtf_pkg::ST_EXTRA;
                     nxt_st.cycles = st_ff.cycles + `MTF_CYC_ONE;
                  end
                  else
                  begin
                     nxt_st.state = mtf_pkg::ST_IDLE;
                     nxt_st.busy = 1'b0;
                  end
               end
            end
         end
         mtf_pkg::ST_EXTRA:
         begin
            nxt_st.clk_cnt = st_ff.clk_cnt + 3'h1;
            if (st_ff.clk_cnt == `MTF_CLK_PER_CYCLE - 3'h1)
            begin
               nxt_st.skip_pending = 1'b0;
               nxt_st.clk_cnt = 3'h0;
               nxt_st.state = mtf_pkg::ST_IDLE;
               nxt_st.busy = 1'b0;
            end
         end
         default: nxt_st.state = mtf_pkg::ST_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end
   assign avs_readdata = st_ff.rdata;
   assign avs_waitrequest = !st_ff.ack;
   assign busy = st_ff.busy;
   assign wdt_clear_pulse = st_ff.wdt_pulse;

   AST_ADJUST_ONLY_C: assert property (@(posedge clk_sys) disable iff (srst)
      (st_ff.state == mtf_pkg::ST_EXEC && st_ff.clk_cnt == 3'h0
      && op == mtf_pkg::OP_DECADJ && !st_ff.skip_pending)
      |=> ($stable(st_ff.status[`MTF_ST_Z]) && $stable(st_ff.status[`MTF_ST_VF])))
      else $error("Decimal adjust changed a flag besides carry");
   AST_TWO_CYCLE: assert property (@(posedge clk_sys) disable iff (srst)
      (st_ff.state == mtf_pkg::ST_EXEC && st_ff.clk_cnt == 3'h0 && op == mtf_pkg::OP_JMP
      && !st_ff.to_pcl && !st_ff.skip_pending) |=> (st_ff.cycles == 2'h2))
      else $error("Jump not two cycles");
   AST_WDT_FLAGS: assert property (@(posedge clk_sys) disable iff (srst)
      wdt_clr |=> (!st_ff.status[`MTF_ST_TMO] && !st_ff.status[`MTF_ST_PWDN]
      && st_ff.wdt_pulse))
      else $error("Watchdog clear left flags");
   AST_NO_WDT_CLR: assert property (@(posedge clk_sys) disable iff (srst)
      (!wdt_clr && st_ff.state == mtf_pkg::ST_EXEC && op == mtf_pkg::OP_WDT1
      && !(bus_req && avs_write)) |=> $stable(st_ff.status[`MTF_ST_TMO]))
      else $error("Pre-clear flags moved");
   AST_HALT_POWERDOWN: assert property (@(posedge clk_sys) disable iff (srst)
      (st_ff.state == mtf_pkg::ST_EXEC && st_ff.clk_cnt == 3'h0 && op == mtf_pkg::OP_HALT
      && !st_ff.skip_pending && !wdt_clr) |=> st_ff.status[`MTF_ST_PWDN])
      else $error("Halt did not set power-down");
   AST_SKIP_EXTRA: assert property (@(posedge clk_sys) disable iff (srst)
      (st_ff.state == mtf_pkg::ST_EXTRA && st_ff.clk_cnt == 3'h0) |=> ##2
      (st_ff.state == mtf_pkg::ST_EXTRA) ##1 (st_ff.state == mtf_pkg::ST_IDLE))
      else $error("Skip cycle length");
   AST_LOGIC_Z: assert property (@(posedge clk_sys) disable iff (srst)
      (st_ff.state == mtf_pkg::ST_EXEC && st_ff.clk_cnt == 3'h0 && op == mtf_pkg::OP_AND
      && !st_ff.skip_pending && !(bus_req && avs_write))
      |=> $stable(st_ff.status[`MTF_ST_C]))
      else $error("AND moved carry");
   AST_PC_LOW_EXTRA: assert property (@(posedge clk_sys) disable iff (srst)
      (st_ff.state == mtf_pkg::ST_EXEC && st_ff.clk_cnt == 3'h0
      && (op == mtf_pkg::OP_MOV_MA || op == mtf_pkg::OP_SET)
      && st_ff.to_pcl && !st_ff.skip_pending) |=> (st_ff.cycles == 2'h2))
      else $error("PC low write not extended");
   COV_SKIP: cover property (@(posedge clk_sys) st_ff.state == mtf_pkg::ST_EXTRA);
   COV_WDT: cover property (@(posedge clk_sys) wdt_clr);
   COV_TRD: cover property (@(posedge clk_sys) st_ff.state == mtf_pkg::ST_EXEC && op == mtf_pkg::OP_TRDL);
endmodule // mtf_core

// ==== bench/mtf_rom_model.sv ====
// Program memory model giving one 15-bit word per address
module mtf_rom_model (
   // Lookup
   input wire logic [11:0] addr,
   output logic [14:0] word
);
   timeunit 1ns;
   timeprecision 1ns;
   // Both halves vary with the address, so a swapped half shows up
   assign word = {addr[6:0] ^ 7'h2A, addr[7:0] + 8'h5B};
endmodule // mtf_rom_model

// ==== bench/testbench.sv ====
// Self-checking bench for the instruction timing and flag block
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic [31:0] rd;
   logic avs_waitrequest;
   logic busy;
   logic wdt_clear_pulse;
   logic seen_clr = 1'b0;
   logic [14:0] rom_w;
   int miscompares = 0;
   int n_checks = 0;
   int a, m, s, r, b, c, e, k, n;
   int sk[4] = '{0, 5, 255, 3};
   mtf_pkg::mtf_op_t ops[10] = '{mtf_pkg::OP_NOP, mtf_pkg::OP_MOV_AM, mtf_pkg::OP_BSET,
      mtf_pkg::OP_SET, mtf_pkg::OP_JMP, mtf_pkg::OP_CALL, mtf_pkg::OP_RET,
      mtf_pkg::OP_RETAX, mtf_pkg::OP_INTRET, mtf_pkg::OP_TRDL};
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
      if (wdt_clear_pulse === 1'b1)
         seen_clr = 1'b1;
   mtf_core mtf_core_i (.clk_sys, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .busy, .wdt_clear_pulse);
   mtf_rom_model mtf_rom_model_i (.addr(12'(a)), .word(rom_w));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Request held until waitrequest is seen low at a rising edge
   task av(input logic w, input logic [3:0] ad, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= ad;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      // Only the watchdog process ends a wait that never completes
      do
         @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task rdchk(input logic [3:0] ad, input int ex, input string nm);
      av(1'b0, ad, 32'h0);
      chk(nm, rd, 32'(ex));
   endtask
   task ld(input int aa, input int mm, input int ss);
      av(1'b1, 4'h0, 32'(aa));
      av(1'b1, 4'h1, 32'(mm));
      av(1'b1, 4'h3, 32'(ss));
   endtask
   // Counts clocks with busy high; one instruction cycle is four clocks
   task exec(input int op, input int cy);
      av(1'b1, 4'h2, 32'(op));
      for (n = 1; n < 99 && busy === 1'b1; n++)
         @(posedge clk_sys);
      chk("cycles", 32'(n - 1), 32'(cy * 4));
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      void'($urandom(32'h2B4C));
      repeat (6) @(posedge clk_sys);
      srst <= 1'b0;
      for (k = 0; k < 16; k++)
      begin
         a = $urandom % 256;
         m = $urandom % 256;
         s = $urandom % 16;
         b = (k % 4 > 1) ? (m ^ 255) : m;
         c = (k % 4 == 0) ? 0 : (k % 4 == 2) ? 1 : s[1];
         r = a + b + c;
         e = ((r >> 8) << 1) | ((((a & 15) + (b & 15) + c) >> 4) << 2) | ((r & 255) == 0);
         e = e | ((((a ^ r) & (b ^ r) & 128) >> 7) << 3);
         ld(a, m, s);
         exec(mtf_pkg::OP_ADD + k % 4, 1);
         rdchk(4'h0, r & 255, "acc");
         rdchk(4'h3, e, "status");
      end
      $display("arithmetic test done");
      for (k = 0; k < 10; k++)
      begin
         m = $urandom % 256;
         s = $urandom % 16;
         r = (k == 0) ? a & m : (k == 1) ? a | m : (k == 2) ? a ^ m : (k == 3) ? ~m : (k == 4) ?
            m + 1 : (k == 5) ? m - 1 : (k == 6) ? (m >> 1) | (m << 7) : (k == 7) ?
            (m << 1) | (m >> 7) : (k == 8) ? (m >> 1) | (s[1] << 7) : (m << 1) | s[1];
         r = r & 255;
         e = (k < 6) ? (s & 14) | (r == 0) : (k < 8) ? s : (s & 13) | ((k == 8 ? m & 1 : m >> 7) << 1);
         ld(a, m, s);
         // Odd steps send the result to memory through the destination bit
         exec((mtf_pkg::OP_AND + k) | ((k % 2) << 8), 1);
         rdchk(4'(k % 2), r, "result");
         rdchk(4'h3, e, "status");
      end
      for (k = 0; k < 6; k++)
      begin
         a = $urandom % 256;
         s = $urandom % 16;
         c = (a & 15) + ((a % 16 > 9 || s[2]) ? 6 : 0);
         // Low adjust carries upward only when aux carry was clear
         b = (a >> 4) + (a % 16 > 9 && !s[2]);
         e = (b > 9 || s[1]) ? s | 2 : s & 13;
         b = b + ((b > 9 || s[1]) ? 6 : 0);
         ld(a, 0, s);
         exec(mtf_pkg::OP_DECADJ, 1);
         rdchk(4'h1, ((b & 15) << 4) | (c & 15), "mem");
         rdchk(4'h3, e, "status");
      end
      $display("logic and adjust test done");
      for (k = 0; k < 10; k++)
      begin
         s = $urandom % 16;
         ld(a, 7, s);
         exec(ops[k], k > 3 ? 2 : 1);
         rdchk(4'h3, s, "status");
      end
      exec(mtf_pkg::OP_SET | 'h10000, 2);
      for (k = 0; k < 4; k++)
      begin
         ld(a, sk[k], s);
         e = (k < 2) ? (sk[k] == 0) + 1 : ((sk[k] + 1) % 256 == 0) + 2;
         exec(k < 2 ? mtf_pkg::OP_SZ : mtf_pkg::OP_INCSKIP | 'h10000, e);
         rdchk(4'h0, a, "acc");
         rdchk(4'h3, s, "status");
      end
      a = $urandom % 256;
      ld(a, 0, 0);
      av(1'b1, 4'h8, 32'(rom_w));
      exec(mtf_pkg::OP_TRDC, 2);
      rdchk(4'h1, rom_w[7:0], "mem");
      rdchk(4'h4, rom_w[14:8], "table high");
      $display("timing test done");
      av(1'b1, 4'h7, 32'h1);
      av(1'b1, 4'h3, 32'h30);
      seen_clr = 1'b0;
      exec(mtf_pkg::OP_WDT1, 1);
      rdchk(4'h3, 'h30, "status");
      chk("wdt clear", seen_clr, 0);
      exec(mtf_pkg::OP_WDT2, 1);
      rdchk(4'h3, 0, "status");
      chk("wdt clear", seen_clr, 1);
      av(1'b1, 4'h7, 32'h0);
      av(1'b1, 4'h3, 32'h30);
      seen_clr = 1'b0;
      exec(mtf_pkg::OP_CLRWDT, 1);
      rdchk(4'h3, 0, "status");
      chk("wdt clear", seen_clr, 1);
      exec(mtf_pkg::OP_HALT, 1);
      rdchk(4'h3, 'h10, "status");
      rdchk(4'hF, 0, "unmapped");
      $display("watchdog test done");
      final_report;
   end
   initial
   begin
      #200000;
      miscompares++;
      final_report;
   end
endmodule // testbench
